/* File: shared/pin_mux_pkg.sv */
// shared constants for the low-power pin multiplexer
package pin_mux_pkg;
  // ==========================================================
  // pin and function counts
  localparam int unsigned LP_PIN_COUNT  = 22;
  localparam int unsigned MAIN_FN_COUNT = 5;
  localparam int unsigned FN_SEL_W      = 3;
  localparam int unsigned LP_SEL_W      = 2;
  // ==========================================================
  // low-power function slots
  localparam logic [1:0] LP_FN_GPIO     = 2'h0;
  localparam logic [1:0] LP_FN_I2C      = 2'h3;
  localparam int unsigned I2C_PIN_COUNT = 4;
  // ==========================================================
  // usb data pins, low-power numbering
  localparam int unsigned USB_DM_PIN = 19;
  localparam int unsigned USB_DP_PIN = 20;
  // ==========================================================
  // debug port and boot straps
  localparam int unsigned DBG_W   = 4;
  localparam int unsigned STRAP_W = 2;
  // ==========================================================
  // reset values
  localparam logic [4:0] FN_DEFAULT_HIGH_RST = 5'h1E;
  localparam logic       PIN_FN_SEL_RST      = 1'h0;
  localparam logic       I2C_IDLE            = 1'h1;
  // ==========================================================
  // who owns a pad
  typedef enum logic [1:0] {
    OWN_MAIN,
    OWN_USB,
    OWN_LP
  } pad_owner_t;
endpackage

/* File: rtl/lp_pin_slice.sv */
// per-pad routing slice, combinational next values
`timescale 1ns/1ps
`default_nettype none
module lp_pin_slice
  import pin_mux_pkg::*;
#(
  parameter int unsigned         NUM_FN   = MAIN_FN_COUNT,
  parameter logic [NUM_FN-1:0]   DEF_HIGH = '0,
  parameter bit                  HAS_I2C  = 1'b0,
  parameter bit                  IS_USB   = 1'b0
) (
  // mode
  input  wire logic                deep_sleep,
  input  wire logic                usb_attached,
  input  wire logic                pad_in,
  // main multiplexer
  input  wire logic [FN_SEL_W-1:0] fn_sel,
  input  wire logic [NUM_FN-1:0]   fn_out,
  input  wire logic [NUM_FN-1:0]   fn_oe,
  output logic      [NUM_FN-1:0]   next_fn_in,
  // low-power multiplexer
  input  wire logic [LP_SEL_W-1:0] lp_sel,
  input  wire logic                lp_gpio_out,
  input  wire logic                lp_gpio_oe,
  input  wire logic                lp_i2c_oe,
  output logic                     next_lp_gpio_in,
  output logic                     next_lp_i2c_in,
  // usb serial/debug controller
  input  wire logic                usb_out,
  input  wire logic                usb_oe,
  // pad
  output logic                     next_pad_out,
  output logic                     next_pad_oe
);
  pad_owner_t owner;

  always_comb begin
    if (deep_sleep) begin
      owner = OWN_LP;
    end else if (IS_USB && usb_attached) begin
      owner = OWN_USB;
    end else begin
      owner = OWN_MAIN;
    end
  end

  // unselected peripheral inputs see their fixed default
  always_comb begin
    for (int f = 0; f < NUM_FN; f++) begin
      if (owner == OWN_MAIN && fn_sel == FN_SEL_W'(f)) begin
        next_fn_in[f] = pad_in;
      end else begin
        next_fn_in[f] = DEF_HIGH[f];
      end
    end
  end

  always_comb begin
    next_pad_out    = 1'b0;
    next_pad_oe     = 1'b0;
    next_lp_gpio_in = 1'b0;
    next_lp_i2c_in  = I2C_IDLE;
    case (owner)
      OWN_MAIN: begin
        if ({1'b0, fn_sel} < (FN_SEL_W + 1)'(NUM_FN)) begin
          next_pad_out = fn_out[fn_sel];
          next_pad_oe  = fn_oe[fn_sel];
        end
      end
      OWN_USB: begin
        next_pad_out = usb_out;
        next_pad_oe  = usb_oe;
      end
      OWN_LP: begin
        if (lp_sel == LP_FN_GPIO) begin
          next_pad_out    = lp_gpio_out;
          next_pad_oe     = lp_gpio_oe;
          next_lp_gpio_in = pad_in;
        end else if (HAS_I2C && lp_sel == LP_FN_I2C) begin
          next_pad_out   = 1'b0;
          next_pad_oe    = lp_i2c_oe;
          next_lp_i2c_in = pad_in;
        end
      end
      default: begin
        next_pad_oe = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

/* File: rtl/low_power_io_pin_mux.sv */
// low-power pin multiplexer top: main mux, deep-sleep mux, usb, debug
`timescale 1ns/1ps
`default_nettype none
// How it works
// - a default-high peripheral input reads one while its pad is elsewhere.
// - a default-low peripheral input reads zero while its pad is elsewhere.
// - in deep sleep the main mux lets go and the low-power mux owns pads.
// - each low-power pad can be a coprocessor gpio; only pads 0-3 can instead be a peripheral (i2c) pin.
// - slot F3 gives i2c, pads 0/1 clock/data of bus 0, pads 2/3 of bus 1.
// - low-power selects are indexed by low-power gpio number.
// - usb pads belong to the usb controller until the select bit is set.
// - the debug port may be fed by the usb controller, freeing its pads.
module low_power_io_pin_mux
  import pin_mux_pkg::*;
#(
  parameter int unsigned          NUM_PINS = LP_PIN_COUNT,
  parameter int unsigned          NUM_FN   = MAIN_FN_COUNT,
  parameter logic [NUM_FN-1:0]    FN_DEFAULT_HIGH =
                                    NUM_FN'(FN_DEFAULT_HIGH_RST)
) (
  // clock, reset, enable
  input  wire logic                               core_clk,
  input  wire logic                               rst_n,
  input  wire logic                               clk_en,
  // pads
  input  wire logic [NUM_PINS-1:0]                pad_in,
  output logic      [NUM_PINS-1:0]                pad_out,
  output logic      [NUM_PINS-1:0]                pad_oe,
  // main multiplexer
  input  wire logic [NUM_PINS-1:0][FN_SEL_W-1:0]  fn_sel,
  input  wire logic [NUM_PINS-1:0][NUM_FN-1:0]    fn_out,
  input  wire logic [NUM_PINS-1:0][NUM_FN-1:0]    fn_oe,
  output logic      [NUM_PINS-1:0][NUM_FN-1:0]    fn_in,
  // low-power multiplexer
  input  wire logic                               deep_sleep,
  input  wire logic [NUM_PINS-1:0][LP_SEL_W-1:0]  lp_sel,
  input  wire logic [NUM_PINS-1:0]                lp_gpio_out,
  input  wire logic [NUM_PINS-1:0]                lp_gpio_oe,
  output logic      [NUM_PINS-1:0]                lp_gpio_in,
  // low-power i2c, oe high pulls the line low
  input  wire logic [1:0]                         lp_i2c_scl_oe,
  input  wire logic [1:0]                         lp_i2c_sda_oe,
  output logic      [1:0]                         lp_i2c_scl_in,
  output logic      [1:0]                         lp_i2c_sda_in,
  // usb serial/debug controller, bit 0 d-, bit 1 d+
  input  wire logic                               pin_fn_sel_wr,
  input  wire logic                               pin_fn_sel_data,
  output logic                                    pin_function_select,
  input  wire logic [1:0]                         usb_ser_out,
  input  wire logic [1:0]                         usb_ser_oe,
  output logic      [1:0]                         usb_ser_in,
  // debug test port source
  input  wire logic                               dbg_src_usb,
  input  wire logic [DBG_W-1:0]                   dbg_pad_in,
  input  wire logic [DBG_W-1:0]                   usb_dbg_sig,
  output logic      [DBG_W-1:0]                   dbg_sig,
  output logic                                    dbg_pads_free,
  // boot straps
  input  wire logic [STRAP_W-1:0]                 strap_in,
  output logic      [STRAP_W-1:0]                 strap_value
);
  // ==========================================================
  // elaboration checks
  if (NUM_PINS <= USB_DP_PIN || NUM_PINS < I2C_PIN_COUNT) begin : g_chk_pins
    $error("NUM_PINS too small for usb and i2c pads");
  end
  if (NUM_FN < 1 || NUM_FN > (1 << FN_SEL_W)) begin : g_chk_fn
    $error("NUM_FN does not fit the select width");
  end

  logic [NUM_PINS-1:0] i2c_in;
  logic                strap_done;

  // ==========================================================
  // usb function select bit
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pin_function_select <= PIN_FN_SEL_RST;
    end else if (clk_en && pin_fn_sel_wr) begin
      pin_function_select <= pin_fn_sel_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      usb_ser_in <= '0;
    end else if (clk_en) begin
      if (!deep_sleep && !pin_function_select) begin
        usb_ser_in <= {pad_in[USB_DP_PIN], pad_in[USB_DM_PIN]};
      end else begin
        usb_ser_in <= '0;
      end
    end
  end

  // ==========================================================
  // per-pad slices, indexed by low-power gpio number
  for (genvar g = 0; g < NUM_PINS; g++) begin : g_pad
    localparam bit HAS_I2C = (g < I2C_PIN_COUNT);
    localparam bit IS_USB  = (g == USB_DM_PIN) || (g == USB_DP_PIN);
    localparam int USB_IDX = (g == USB_DP_PIN) ? 1 : 0;
    localparam int I2C_CH  = (g / 2) % 2;
    logic              i2c_oe;
    logic              n_out;
    logic              n_oe;
    logic [NUM_FN-1:0] n_fn_in;
    logic              n_gpio_in;
    logic              n_i2c_in;

    // even pads carry clock, odd pads carry data
    assign i2c_oe = !HAS_I2C ? 1'b0 :
                    ((g % 2) == 0) ? lp_i2c_scl_oe[I2C_CH]
                                   : lp_i2c_sda_oe[I2C_CH];

    lp_pin_slice #(
      .NUM_FN   (NUM_FN),
      .DEF_HIGH (FN_DEFAULT_HIGH),
      .HAS_I2C  (HAS_I2C),
      .IS_USB   (IS_USB)
    ) u_slice (
      .deep_sleep      (deep_sleep),
      .usb_attached    (!pin_function_select),
      .pad_in          (pad_in[g]),
      .fn_sel          (fn_sel[g]),
      .fn_out          (fn_out[g]),
      .fn_oe           (fn_oe[g]),
      .next_fn_in      (n_fn_in),
      .lp_sel          (lp_sel[g]),
      .lp_gpio_out     (lp_gpio_out[g]),
      .lp_gpio_oe      (lp_gpio_oe[g]),
      .lp_i2c_oe       (i2c_oe),
      .next_lp_gpio_in (n_gpio_in),
      .next_lp_i2c_in  (n_i2c_in),
      .usb_out         (usb_ser_out[USB_IDX]),
      .usb_oe          (usb_ser_oe[USB_IDX]),
      .next_pad_out    (n_out),
      .next_pad_oe     (n_oe)
    );

    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        pad_out[g]    <= 1'b0;
        pad_oe[g]     <= 1'b0;
        fn_in[g]      <= FN_DEFAULT_HIGH;
        lp_gpio_in[g] <= 1'b0;
        i2c_in[g]     <= I2C_IDLE;
      end else if (clk_en) begin
        pad_out[g]    <= n_out;
        pad_oe[g]     <= n_oe;
        fn_in[g]      <= n_fn_in;
        lp_gpio_in[g] <= n_gpio_in;
        i2c_in[g]     <= n_i2c_in;
      end
    end
  end

  assign lp_i2c_scl_in = {i2c_in[2], i2c_in[0]};
  assign lp_i2c_sda_in = {i2c_in[3], i2c_in[1]};

  // ==========================================================
  // debug test port source
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dbg_sig       <= '0;
      dbg_pads_free <= 1'b0;
    end else if (clk_en) begin
      dbg_sig       <= dbg_src_usb ? usb_dbg_sig : dbg_pad_in;
      dbg_pads_free <= dbg_src_usb;
    end
  end

  // ==========================================================
  // boot straps, taken once on the first enabled edge after reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      strap_value <= '0;
      strap_done  <= 1'b0;
    end else if (clk_en && !strap_done) begin
      strap_value <= strap_in;
      strap_done  <= 1'b1;
    end
  end

  // ==========================================================
  // assertions
  property p_default_high;
    @(posedge core_clk) disable iff (!rst_n)
      (FN_DEFAULT_HIGH[1] && clk_en && fn_sel[1] != FN_SEL_W'(1))
      |=> (fn_in[1][1] == 1'b1);
  endproperty
  a_default_high: assert property (p_default_high)
    else $error("default-high input not held at one");

  property p_default_low;
    @(posedge core_clk) disable iff (!rst_n)
      (!FN_DEFAULT_HIGH[0] && clk_en && fn_sel[1] != '0)
      |=> (fn_in[1][0] == 1'b0);
  endproperty
  a_default_low: assert property (p_default_low)
    else $error("default-low input not held at zero");

  property p_sleep_main_off;
    @(posedge core_clk) disable iff (!rst_n)
      (clk_en && deep_sleep) |=> (fn_in[2] == FN_DEFAULT_HIGH);
  endproperty
  a_sleep_main_off: assert property (p_sleep_main_off)
    else $error("main mux still routing in deep sleep");

  property p_lp_gpio;
    @(posedge core_clk) disable iff (!rst_n)
      (clk_en && deep_sleep && lp_sel[5] == LP_FN_GPIO)
      |=> (lp_gpio_in[5] == $past(pad_in[5]))
          && (pad_oe[5] == $past(lp_gpio_oe[5]));
  endproperty
  a_lp_gpio: assert property (p_lp_gpio)
    else $error("low-power gpio not routed in deep sleep");

  property p_i2c_scl0;
    @(posedge core_clk) disable iff (!rst_n)
      (clk_en && deep_sleep && lp_sel[0] == LP_FN_I2C)
      |=> (lp_i2c_scl_in[0] == $past(pad_in[0]))
          && (pad_oe[0] == $past(lp_i2c_scl_oe[0]))
          && !pad_out[0];
  endproperty
  a_i2c_scl0: assert property (p_i2c_scl0)
    else $error("i2c bus 0 clock not on pad 0");

  property p_i2c_sda1;
    @(posedge core_clk) disable iff (!rst_n)
      (clk_en && deep_sleep && lp_sel[3] == LP_FN_I2C)
      |=> (lp_i2c_sda_in[1] == $past(pad_in[3]));
  endproperty
  a_i2c_sda1: assert property (p_i2c_sda1)
    else $error("i2c bus 1 data not on low-power pad 3");

  property p_usb_reset;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(rst_n) |-> !pin_function_select ##1
        (!$past(clk_en) || $past(deep_sleep)
         || pad_out[USB_DP_PIN] == $past(usb_ser_out[1]));
  endproperty
  a_usb_reset: assert property (p_usb_reset)
    else $error("usb pads not with usb controller after reset");

  property p_usb_route;
    @(posedge core_clk) disable iff (!rst_n)
      (clk_en && !deep_sleep && !pin_function_select && !pin_fn_sel_wr)
      |=> (pad_oe[USB_DM_PIN] == $past(usb_ser_oe[0]))
          && (usb_ser_in[1] == $past(pad_in[USB_DP_PIN]));
  endproperty
  a_usb_route: assert property (p_usb_route)
    else $error("usb pads not routed to usb controller");

  property p_dbg_usb;
    @(posedge core_clk) disable iff (!rst_n)
      (clk_en && dbg_src_usb)
      |=> (dbg_sig == $past(usb_dbg_sig)) && dbg_pads_free;
  endproperty
  a_dbg_usb: assert property (p_dbg_usb)
    else $error("debug port not fed by usb controller");

  property p_strap;
    @(posedge core_clk) disable iff (!rst_n)
      (clk_en && !strap_done) |=> (strap_value == $past(strap_in))
        ##1 (strap_value == $past(strap_value) || !strap_done);
  endproperty
  a_strap: assert property (p_strap)
    else $error("boot strap not captured once");
endmodule
`default_nettype wire

/* File: dv/pad_world.sv */
// far-side model: pads with outside drivers, pull-ups and boot straps
`timescale 1ns/1ps
`default_nettype none
module pad_world
  import pin_mux_pkg::*;
(
  // clock
  input  wire logic                    core_clk,
  // pads
  input  wire logic [LP_PIN_COUNT-1:0] pad_out,
  input  wire logic [LP_PIN_COUNT-1:0] pad_oe,
  input  wire logic [LP_PIN_COUNT-1:0] ext_val,
  input  wire logic [LP_PIN_COUNT-1:0] ext_oe,
  output logic      [LP_PIN_COUNT-1:0] pad_in,
  // straps
  output logic      [STRAP_W-1:0]      strap_in
);
  logic [LP_PIN_COUNT-1:0] drift = '0;
  // undriven pads wander, i2c pads pulled up
  always @(posedge core_clk) drift <= ~drift;
  always_comb begin
    for (int i = 0; i < LP_PIN_COUNT; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_oe[i]) pad_in[i] = ext_val[i];
      else if (i < I2C_PIN_COUNT) pad_in[i] = 1'h1;
      else pad_in[i] = drift[i];
    end
  end
  // straps held from power-up on
  assign strap_in = 2'h2;
endmodule
`default_nettype wire

/* File: dv/low_power_io_pin_mux_tb.sv */
// self-checking bench for the low-power pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module low_power_io_pin_mux_tb;
  import pin_mux_pkg::*;
  localparam int unsigned NP = LP_PIN_COUNT;
  localparam int unsigned NF = MAIN_FN_COUNT;
  // ==========================================================
  // signals
  logic                        core_clk;
  logic                        rst_n;
  logic                        clk_en;
  logic [NP-1:0]               pad_in, pad_out, pad_oe, ext_val, ext_oe;
  logic [NP-1:0][FN_SEL_W-1:0] fn_sel;
  logic [NP-1:0][NF-1:0]       fn_out, fn_oe, fn_in;
  logic                        deep_sleep;
  logic [NP-1:0][LP_SEL_W-1:0] lp_sel;
  logic [NP-1:0]               lp_gpio_out, lp_gpio_oe, lp_gpio_in;
  logic [1:0]                  lp_i2c_scl_oe, lp_i2c_sda_oe;
  logic [1:0]                  lp_i2c_scl_in, lp_i2c_sda_in;
  logic                        pin_fn_sel_wr, pin_fn_sel_data;
  logic                        pin_function_select;
  logic [1:0]                  usb_ser_out, usb_ser_oe, usb_ser_in;
  logic                        dbg_src_usb, dbg_pads_free;
  logic [DBG_W-1:0]            dbg_pad_in, usb_dbg_sig, dbg_sig;
  logic [STRAP_W-1:0]          strap_in, strap_value;
  int                          err_count = 0;
  int                          n_tests = 0;
  // ==========================================================
  // instances
  low_power_io_pin_mux u_low_power_io_pin_mux (
    .core_clk, .rst_n, .clk_en, .pad_in, .pad_out, .pad_oe, .fn_sel,
    .fn_out, .fn_oe, .fn_in, .deep_sleep, .lp_sel, .lp_gpio_out,
    .lp_gpio_oe, .lp_gpio_in, .lp_i2c_scl_oe, .lp_i2c_sda_oe,
    .lp_i2c_scl_in, .lp_i2c_sda_in, .pin_fn_sel_wr, .pin_fn_sel_data,
    .pin_function_select, .usb_ser_out, .usb_ser_oe, .usb_ser_in,
    .dbg_src_usb, .dbg_pad_in, .usb_dbg_sig, .dbg_sig, .dbg_pads_free,
    .strap_in, .strap_value
  );
  pad_world u_pad_world (
    .core_clk, .pad_out, .pad_oe, .ext_val, .ext_oe, .pad_in, .strap_in
  );
  // ==========================================================
  // clock and helpers
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] got, exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    chk(fn_in[5], FN_DEFAULT_HIGH_RST, "defaults");
    chk(pin_function_select, 1'h0, "select rst");
    chk(strap_value, strap_in, "strap");
  endtask
  task automatic t_main;
    fn_sel[5] = 3'h1;
    fn_oe[5] = 5'h02;
    fn_out[5] = 5'h02;
    settle(2);
    chk(pad_oe[5], 1'h1, "main oe");
    chk(pad_out[5], 1'h1, "main out");
    fn_oe[5] = '0;
    ext_oe[5] = 1'h1;
    ext_val[5] = 1'h0;
    settle(3);
    chk(fn_in[5], 5'h1C, "pad low slot1");
    ext_val[5] = 1'h1;
    fn_sel[5] = 3'h0;
    settle(3);
    chk(fn_in[5], 5'h1F, "pad high slot0");
    fn_sel[5] = 3'h7;
    fn_oe[5] = '1;
    settle(2);
    chk(pad_oe[5], 1'h0, "no function");
  endtask
  task automatic t_sleep_i2c;
    fn_sel[5] = 3'h1;
    ext_val[5] = 1'h0;
    deep_sleep = 1'h1;
    for (int i = 0; i < 5; i++) lp_sel[i] = LP_FN_I2C;
    lp_i2c_scl_oe = 2'h1;
    settle(3);
    chk({pad_oe[0], pad_out[0]}, 2'h2, "scl0 pad");
    chk(lp_i2c_scl_in, 2'h2, "scl in");
    chk(lp_i2c_sda_in, 2'h3, "sda idle");
    chk(pad_oe[4], 1'h0, "i2c pad4");
    chk(pad_oe[5], 1'h0, "main off");
    chk(fn_in[5], FN_DEFAULT_HIGH_RST, "main in off");
    lp_i2c_scl_oe = 2'h0;
    lp_i2c_sda_oe = 2'h2;
    settle(3);
    chk({pad_oe[3], pad_out[3]}, 2'h2, "sda1 pad");
    chk(lp_i2c_sda_in, 2'h1, "sda in");
    chk(lp_i2c_scl_in, 2'h3, "scl free");
    lp_i2c_sda_oe = 2'h0;
  endtask
  task automatic t_lp_gpio;
    lp_gpio_oe[7] = 1'h1;
    lp_gpio_out[7] = 1'h1;
    ext_oe[9:8] = 2'h3;
    ext_val[9:8] = 2'h3;
    lp_sel[9] = 2'h1;
    settle(3);
    chk({pad_oe[7], pad_out[7]}, 2'h3, "lp gpio drive");
    chk(lp_gpio_in[9:7], 3'h3, "lp gpio in");
    chk(pad_oe[9], 1'h0, "lp slot1");
    deep_sleep = 1'h0;
    settle(2);
    chk(lp_gpio_in[8], 1'h0, "awake lp in");
  endtask
  task automatic t_usb;
    usb_ser_oe = 2'h1;
    usb_ser_out = 2'h1;
    ext_oe[USB_DP_PIN] = 1'h1;
    ext_val[USB_DP_PIN] = 1'h1;
    settle(3);
    chk({pad_oe[USB_DM_PIN], pad_out[USB_DM_PIN]}, 2'h3, "usb d-");
    chk(usb_ser_in, 2'h3, "usb in");
    pin_fn_sel_wr = 1'h1;
    pin_fn_sel_data = 1'h1;
    settle(1);
    pin_fn_sel_wr = 1'h0;
    chk(pin_function_select, 1'h1, "select set");
    fn_sel[USB_DM_PIN] = 3'h1;
    fn_oe[USB_DM_PIN] = 5'h02;
    fn_out[USB_DM_PIN] = 5'h00;
    settle(2);
    chk({pad_oe[USB_DM_PIN], pad_out[USB_DM_PIN]}, 2'h2, "gpio d-");
    chk(usb_ser_in, 2'h0, "usb off");
  endtask
  task automatic t_debug;
    dbg_pad_in = 4'h5;
    usb_dbg_sig = 4'hA;
    settle(1);
    chk({dbg_pads_free, dbg_sig}, 5'h05, "dbg pads");
    dbg_src_usb = 1'h1;
    settle(1);
    chk({dbg_pads_free, dbg_sig}, 5'h1A, "dbg usb");
    clk_en = 1'h0;
    dbg_src_usb = 1'h0;
    settle(2);
    chk({dbg_pads_free, dbg_sig}, 5'h1A, "frozen");
    clk_en = 1'h1;
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    rst_n = 1'h0;
    clk_en = 1'h1;
    ext_val = '0;
    ext_oe = '0;
    fn_sel = '1;
    fn_out = '0;
    fn_oe = '0;
    deep_sleep = 1'h0;
    lp_sel = '0;
    lp_gpio_out = '0;
    lp_gpio_oe = '0;
    lp_i2c_scl_oe = 2'h0;
    lp_i2c_sda_oe = 2'h0;
    pin_fn_sel_wr = 1'h0;
    pin_fn_sel_data = 1'h0;
    usb_ser_out = 2'h0;
    usb_ser_oe = 2'h0;
    dbg_src_usb = 1'h0;
    dbg_pad_in = 4'h0;
    usb_dbg_sig = 4'h0;
    settle(3);
    rst_n = 1'h1;
    settle(2);
    t_reset;
    t_main;
    t_sleep_i2c;
    t_lp_gpio;
    t_usb;
    t_debug;
    print_verdict;
  end
  initial begin
    repeat (2000) @(posedge core_clk);
    err_count++;
    print_verdict;
  end
endmodule
`default_nettype wire
